// ===== hw/ebi_pkg.sv
// Package: constants and types for the external bus interface
package ebi_pkg;
  // ---------------------------------------------------------------
  // Bus shape
  // ---------------------------------------------------------------
  localparam int unsigned NUM_AREAS      = 4;
  localparam int unsigned DATA_W         = 16;
  localparam int unsigned ADDR_W         = 24;
  localparam int unsigned UPPER_W_LARGE  = 8;
  localparam int unsigned UPPER_W_SMALL  = 6;
  localparam int unsigned WAIT_W         = 3;
  // ---------------------------------------------------------------
  // Reset values and cycle lengths
  // ---------------------------------------------------------------
  localparam logic [2:0] WAIT_RESET      = 3'h7;
  localparam logic       MODE_RESET      = 1'h0;
  localparam logic       MODE_MUX        = 1'h0;
  localparam logic       MODE_SEP        = 1'h1;
  localparam logic       WIDTH_RESET     = 1'h1;
  localparam int unsigned MUX_MIN_CLOCKS = 3;
  localparam int unsigned SEP_MIN_CLOCKS = 2;
  // Area decode on address bits 22:21
  localparam int unsigned AREA_LSB       = 21;

  typedef struct packed {
    logic        write;
    logic [1:0]  byte_en;
    logic [23:0] addr;
    logic [15:0] wdata;
    logic        internal;
  } ebi_req_t;

  typedef struct packed {
    logic [3:0]  area_select_n;
    logic        low_byte_write_strobe_n;
    logic        high_byte_write_strobe_n;
    logic        read_strobe_n;
    logic        addr_latch_strobe;
  } ebi_ctl_t;
endpackage

// ===== hw/ebi_sync.sv
// Two-flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module ebi_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_sync_out;

  always_comb begin
    next_stage1   = async_in;
    next_sync_out = stage1;
    if (srst) begin
      next_stage1   = '0;
      next_sync_out = '0;
    end
  end

  always_ff @(posedge clk) begin
    stage1   <= next_stage1;
    sync_out <= next_sync_out;
  end
endmodule
`default_nettype wire

// ===== hw/ebi_top.sv
// External bus interface: cycle engine, pin drive and hold handshake
// ---------------------------------------------------------------
// Summary of operation
// [RQ1] Multiplexed cycle lasts three clocks minimum, separate cycle two.
// [RQ2] Four active-low area selects, one per external address space.
// [RQ3] Each area is set to an 8-bit or 16-bit data path.
// [RQ4] Zero to seven programmed wait states per area.
// [RQ5] External wait input stretches the cycle while asserted.
// [RQ6] Multiplexed: shared pins carry address then data; strobes driven.
// [RQ7] Separate: shared pins carry data; low address separate; no latch strobe.
// [RQ8] Small variant has six upper address lines, large has eight.
// [RQ9] Separate mode internal access: data released, controls inactive.
// [RQ10] Multiplexed internal access: controls and selects stay inactive.
// [RQ11] Internal ROM writes run as full external write cycles.
// [RQ12] Upper address pins follow bus when their function select is 1.
// [RQ13] Shared pins follow bus when their function select is 1.
// [RQ14] Mode bit: 0 multiplexed, 1 separate, resets to multiplexed.
// [RQ15] All areas reset to seven wait states.
// [RQ16] Hold request: finish cycle, release pins, then acknowledge.
// [RQ17] System clock is driven out; bus timing refers to it.
// ---------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module ebi_top #(
  parameter int unsigned UPPER_W = ebi_pkg::UPPER_W_LARGE
) (
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire logic                  link_clk,
  input  wire logic                  bus_mode_select,
  input  wire logic                  cfg_load,
  input  wire logic [3:0]            cfg_area_width16,
  input  wire logic [11:0]           cfg_area_waits,
  input  wire logic                  req_valid,
  output logic                       req_ready,
  input  wire ebi_pkg::ebi_req_t     req,
  output logic                       rsp_valid,
  output logic [15:0]                rsp_rdata,
  output logic                       bus_mode,
  output logic [3:0]                 area_width16,
  output logic [11:0]                area_waits,
  output logic                       busy,
  input  wire logic                  ext_wait,
  input  wire logic                  hold_request,
  output logic                       hold_acknowledge,
  output logic                       system_clock_out,
  output ebi_pkg::ebi_ctl_t          ctl,
  output logic [15:0]                lower_address,
  output logic [UPPER_W-1:0]         upper_address,
  input  wire logic [UPPER_W-1:0]    upper_pin_func_select,
  input  wire logic [UPPER_W-1:0]    upper_port_latch,
  output logic [UPPER_W-1:0]         upper_port_pin,
  input  wire logic [15:0]           lower_pin_func_select,
  input  wire logic [15:0]           lower_port_latch,
  input  wire logic [15:0]           lower_port_dir_out,
  input  wire logic [15:0]           lower_port_pin_in,
  output logic [15:0]                lower_port_pin,
  output logic [15:0]                lower_port_pin_oe,
  input  wire logic                  link_probe,
  output logic                       link_probe_sync
);
  // ---------------------------------------------------------------
  // States
  // ---------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_ADDR  = 7'h02,
    ST_DATA  = 7'h04,
    ST_WAIT  = 7'h08,
    ST_LAST  = 7'h10,
    ST_HOLD  = 7'h20,
    ST_CAPT  = 7'h40
  } ebi_state_t;

  function automatic logic [1:0] area_of(input logic [23:0] a);
    area_of = a[ebi_pkg::AREA_LSB+1:ebi_pkg::AREA_LSB];
  endfunction

  ebi_state_t        state;
  ebi_state_t        next_state;
  ebi_pkg::ebi_req_t cur;
  ebi_pkg::ebi_req_t next_cur;
  logic [2:0]        wait_cnt;
  logic [2:0]        next_wait_cnt;
  logic              half;
  logic              next_half;
  logic [15:0]       rdata_lo;
  logic [15:0]       next_rdata_lo;
  logic              next_rsp_valid;
  logic [15:0]       next_rsp_rdata;
  logic              next_bus_mode;
  logic [3:0]        next_area_width16;
  logic [11:0]       next_area_waits;
  logic              next_hold_acknowledge;
  logic              ext_wait_s;
  logic              hold_req_s;
  logic [15:0]       ad_in_s;
  logic              ext_cycle;
  logic              width16;
  logic [2:0]        waits;
  logic [1:0]        cur_area;
  logic              split;

  // ---------------------------------------------------------------
  // Pin input synchronisers
  // ---------------------------------------------------------------
  ebi_sync #(.W(18)) u_sync (
    .clk      (clk),
    .srst     (srst),
    .async_in ({ext_wait, hold_request, lower_port_pin_in}),
    .sync_out ({ext_wait_s, hold_req_s, ad_in_s})
  );

  // Link-domain probe, crossed as a level
  logic link_q1;
  logic link_q2;
  always_ff @(posedge link_clk) begin
    link_q1 <= link_probe;
  end
  ebi_sync #(.W(1)) u_link_sync (
    .clk      (clk),
    .srst     (srst),
    .async_in (link_q1),
    .sync_out (link_q2)
  );
  assign link_probe_sync = link_q2;

  assign system_clock_out = clk; // RQ17

  // ---------------------------------------------------------------
  // Configuration
  // ---------------------------------------------------------------
  always_comb begin
    next_bus_mode     = bus_mode_select; // RQ14
    next_area_width16 = area_width16;
    next_area_waits   = area_waits;
    if (cfg_load) begin
      next_area_width16 = cfg_area_width16; // RQ3
      next_area_waits   = cfg_area_waits; // RQ4
    end
    if (srst) begin
      next_bus_mode     = ebi_pkg::MODE_RESET; // RQ14
      next_area_width16 = {4{ebi_pkg::WIDTH_RESET}};
      next_area_waits   = {4{ebi_pkg::WAIT_RESET}}; // RQ15
    end
  end

  always_ff @(posedge clk) begin
    bus_mode     <= next_bus_mode;
    area_width16 <= next_area_width16;
    area_waits   <= next_area_waits;
  end

  // ---------------------------------------------------------------
  // Cycle engine
  // ---------------------------------------------------------------
  assign cur_area = area_of(cur.addr);
  assign width16  = area_width16[cur_area];
  assign waits    = area_waits[cur_area*3 +: 3];
  // Internal ROM writes still go out on the pins
  assign ext_cycle = !cur.internal || cur.write; // RQ11
  assign req_ready = (state == ST_IDLE) && !hold_req_s && !srst;
  assign busy      = (state != ST_IDLE);
  // 8-bit area word still needs its high byte
  assign split     = !width16 && (cur.byte_en == 2'h3) && !half;

  always_comb begin
    next_state            = state;
    next_cur              = cur;
    next_wait_cnt         = wait_cnt;
    next_half             = half;
    next_rdata_lo         = rdata_lo;
    next_rsp_valid        = 1'b0;
    next_rsp_rdata        = rsp_rdata;
    next_hold_acknowledge = hold_acknowledge;
    case (state)
      ST_IDLE: begin
        if (hold_req_s) begin
          next_state            = ST_HOLD;
          next_hold_acknowledge = 1'b1; // RQ16
        end else if (req_valid) begin
          next_cur      = req;
          next_half     = 1'b0;
          next_wait_cnt = 3'h0;
          next_state    = (bus_mode == ebi_pkg::MODE_MUX) ?
                          ST_ADDR : ST_DATA; // RQ1
        end
      end
      ST_ADDR: begin
        next_state = ST_DATA; // RQ6
      end
      ST_DATA: begin
        if (ext_cycle && (waits != 3'h0)) begin
          next_state    = ST_WAIT; // RQ4
          next_wait_cnt = 3'h1;
        end else begin
          next_state = ST_LAST;
        end
      end
      ST_WAIT: begin
        if (wait_cnt < waits) begin
          next_wait_cnt = wait_cnt + 3'h1;
        end else if (!ext_wait_s) begin
          next_state = ST_LAST; // RQ5
        end
      end
      ST_LAST: begin
        if (ext_wait_s && ext_cycle) begin
          next_state = ST_LAST; // RQ5
        end else if (ext_cycle && !cur.write) begin
          // Pin data reaches ad_in_s two clocks late
          next_state = ST_CAPT;
        end else if (split) begin
          // 8-bit area: second byte at next address
          next_half      = 1'b1;
          next_cur.addr  = cur.addr + 24'h000001;
          next_cur.wdata = {8'h00, cur.wdata[15:8]}; // RQ3
          next_state     = (bus_mode == ebi_pkg::MODE_MUX) ?
                           ST_ADDR : ST_DATA;
        end else begin
          next_rsp_valid = 1'b1;
          next_rsp_rdata = half ? {ad_in_s[7:0], rdata_lo[7:0]} :
                           ad_in_s;
          next_state     = ST_IDLE;
        end
      end
      ST_CAPT: begin
        if (split) begin
          next_half     = 1'b1;
          next_rdata_lo = {8'h00, ad_in_s[7:0]}; // RQ3
          next_cur.addr = cur.addr + 24'h000001;
          next_state    = (bus_mode == ebi_pkg::MODE_MUX) ?
                          ST_ADDR : ST_DATA;
        end else begin
          next_rsp_valid = 1'b1;
          next_rsp_rdata = half ? {ad_in_s[7:0], rdata_lo[7:0]} :
                           ad_in_s;
          next_state     = ST_IDLE;
        end
      end
      ST_HOLD: begin
        if (!hold_req_s) begin
          next_hold_acknowledge = 1'b0; // RQ16
          next_state            = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (srst) begin
      next_state            = ST_IDLE;
      next_cur              = '0;
      next_wait_cnt         = 3'h0;
      next_half             = 1'b0;
      next_rdata_lo         = 16'h0000;
      next_rsp_valid        = 1'b0;
      next_rsp_rdata        = 16'h0000;
      next_hold_acknowledge = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    state            <= next_state;
    cur              <= next_cur;
    wait_cnt         <= next_wait_cnt;
    half             <= next_half;
    rdata_lo         <= next_rdata_lo;
    rsp_valid        <= next_rsp_valid;
    rsp_rdata        <= next_rsp_rdata;
    hold_acknowledge <= next_hold_acknowledge;
  end

  // ---------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------
  logic        in_cycle;
  logic        data_phase;
  logic [15:0] bus_out;
  logic        bus_oe;
  assign in_cycle   = (state == ST_ADDR) || (state == ST_DATA) ||
                      (state == ST_WAIT) || (state == ST_LAST);
  assign data_phase = (state == ST_DATA) || (state == ST_WAIT) ||
                      (state == ST_LAST);

  always_comb begin
    ctl = '{area_select_n: 4'hF, low_byte_write_strobe_n: 1'b1,
            high_byte_write_strobe_n: 1'b1, read_strobe_n: 1'b1,
            addr_latch_strobe: 1'b0};
    bus_out = 16'h0000;
    bus_oe  = 1'b0;
    if (in_cycle && ext_cycle) begin // RQ9 RQ10
      ctl.area_select_n[cur_area] = 1'b0; // RQ2
      if (state == ST_ADDR) begin
        ctl.addr_latch_strobe = 1'b1; // RQ6 RQ7
        bus_out = cur.addr[15:0];
        bus_oe  = 1'b1;
      end else if (cur.write) begin
        bus_out = cur.wdata;
        bus_oe  = 1'b1;
        ctl.low_byte_write_strobe_n  = !(half || cur.byte_en[0] ||
                                         !width16);
        ctl.high_byte_write_strobe_n = !(width16 && cur.byte_en[1]);
      end else if (data_phase) begin
        ctl.read_strobe_n = 1'b0;
      end
    end
  end

  assign lower_address = cur.addr[15:0]; // RQ7

  genvar gi;
  generate
    for (gi = 0; gi < UPPER_W; gi++) begin : g_upper
      assign upper_address[gi]  = cur.addr[16+gi]; // RQ8
      assign upper_port_pin[gi] = upper_pin_func_select[gi] ?
                                  cur.addr[16+gi] :
                                  upper_port_latch[gi]; // RQ12
    end
    for (gi = 0; gi < 16; gi++) begin : g_lower
      assign lower_port_pin[gi]    = lower_pin_func_select[gi] ?
                                     bus_out[gi] : lower_port_latch[gi];
      assign lower_port_pin_oe[gi] = lower_pin_func_select[gi] ?
                                     (bus_oe && !hold_acknowledge) :
                                     lower_port_dir_out[gi]; // RQ13
    end
  endgenerate
endmodule
`default_nettype wire

// ===== dv/ebi_mem_model.sv
// External memory partner model: byte-strobed RAM with a slow mode
`timescale 1ns/1ps
`default_nettype none
module ebi_mem_model (
  input  wire logic              clk,
  input  wire logic              sep,
  input  wire logic              slow,
  input  wire ebi_pkg::ebi_ctl_t ctl,
  input  wire logic [15:0]       lower_address,
  input  wire logic [15:0]       pin_out,
  input  wire logic [15:0]       pin_oe,
  output logic      [15:0]       pin_in,
  output logic                   ext_wait
);
  logic [15:0] mem [0:255];
  logic [15:0] alat = 16'h0000;
  logic [15:0] last = 16'h0000;
  logic [2:0]  wcnt = 3'h0;
  logic [7:0]  wa;
  logic        sel;
  logic [15:0] drv;
  assign sel = ctl.area_select_n != 4'hF;
  assign wa = sep ? lower_address[8:1] : alat[8:1];
  // Released lines toggle so stale data cannot pass
  assign drv = (sel && pin_oe == 16'h0000) ? mem[wa] : ~last;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & drv);
  assign ext_wait = slow && sel && wcnt != 3'h4;
  always @(posedge clk) begin
    last <= drv;
    if (ctl.addr_latch_strobe) alat <= pin_out;
    wcnt <= !sel ? 3'h0 : (wcnt == 3'h4 ? wcnt : wcnt + 3'h1);
    if (!ctl.low_byte_write_strobe_n) mem[wa][7:0] <= pin_in[7:0];
    if (!ctl.high_byte_write_strobe_n) mem[wa][15:8] <= pin_in[15:8];
  end
endmodule
`default_nettype wire

// ===== dv/ebi_top_chk.sv
// Port-level assertions for the external bus interface
`timescale 1ns/1ps
`default_nettype none
module ebi_top_chk #(
  parameter int unsigned UPPER_W = 8
) (
  input wire logic               clk,
  input wire logic               srst,
  input wire logic               req_valid,
  input wire logic               req_ready,
  input wire ebi_pkg::ebi_req_t  req,
  input wire logic               rsp_valid,
  input wire logic               bus_mode,
  input wire logic               busy,
  input wire logic               hold_request,
  input wire logic               hold_acknowledge,
  input wire ebi_pkg::ebi_ctl_t  ctl,
  input wire logic [UPPER_W-1:0] upper_address,
  input wire logic [UPPER_W-1:0] upper_pin_func_select,
  input wire logic [UPPER_W-1:0] upper_port_latch,
  input wire logic [UPPER_W-1:0] upper_port_pin,
  input wire logic [15:0]        lower_pin_func_select,
  input wire logic [15:0]        lower_port_dir_out,
  input wire logic [15:0]        lower_port_pin_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic tk;
  logic qt;
  assign tk = req_valid && req_ready;
  assign qt = ctl.area_select_n == 4'hF && ctl.read_strobe_n
    && ctl.low_byte_write_strobe_n && ctl.high_byte_write_strobe_n
    && !ctl.addr_latch_strobe;
  property p_one_area; $onehot0(~ctl.area_select_n); endproperty
  a_one_area: assert property (p_one_area)
    else $error("two area selects low");
  property p_mux_len;
    tk && !bus_mode && !req.internal |=> !rsp_valid [*2];
  endproperty
  a_mux_len: assert property (p_mux_len)
    else $error("multiplexed cycle too short");
  property p_sep_len; tk && bus_mode && !req.internal |=> !rsp_valid;
  endproperty
  a_sep_len: assert property (p_sep_len)
    else $error("separate cycle too short");
  property p_sep_strobe; bus_mode |-> !ctl.addr_latch_strobe; endproperty
  a_sep_strobe: assert property (p_sep_strobe)
    else $error("latch strobe in separate mode");
  property p_int_quiet; tk && req.internal && !req.write |=> qt [*2];
  endproperty
  a_int_quiet: assert property (p_int_quiet)
    else $error("controls active on internal read");
  property p_int_hiz; tk && req.internal && !req.write && bus_mode
    && lower_pin_func_select == 16'hFFFF |=> lower_port_pin_oe == 16'h0;
  endproperty
  a_int_hiz: assert property (p_int_hiz)
    else $error("data driven on internal read");
  property p_int_wr; tk && req.internal && req.write
    |-> ##[1:12] !ctl.low_byte_write_strobe_n;
  endproperty
  a_int_wr: assert property (p_int_wr)
    else $error("internal write not sent out");
  property p_hold_free; hold_acknowledge
    |-> qt && busy && !req_ready
    && (lower_port_pin_oe & lower_pin_func_select) == 0;
  endproperty
  a_hold_free: assert property (p_hold_free)
    else $error("bus not released under hold");
  property p_hold_ack; hold_request && !busy && !hold_acknowledge
    && !req_valid |-> ##[1:4] (hold_acknowledge || !hold_request);
  endproperty
  a_hold_ack: assert property (p_hold_ack)
    else $error("hold not acknowledged");
  property p_upper_pin; upper_port_pin == ((upper_address
    & upper_pin_func_select) | (upper_port_latch & ~upper_pin_func_select));
  endproperty
  a_upper_pin: assert property (p_upper_pin)
    else $error("upper pin routing wrong");
  property p_lower_dir; (lower_port_pin_oe & ~lower_pin_func_select)
    == (lower_port_dir_out & ~lower_pin_func_select);
  endproperty
  a_lower_dir: assert property (p_lower_dir)
    else $error("lower pin direction wrong");
endmodule
bind ebi_top ebi_top_chk #(.UPPER_W(UPPER_W)) i_chk (.clk, .srst,
  .req_valid, .req_ready, .req, .rsp_valid, .bus_mode, .busy,
  .hold_request, .hold_acknowledge, .ctl, .upper_address,
  .upper_pin_func_select, .upper_port_latch, .upper_port_pin,
  .lower_pin_func_select, .lower_port_dir_out, .lower_port_pin_oe);
`default_nettype wire

// ===== dv/test_external_bus_interface.sv
// Self-checking bench for the external bus interface
`timescale 1ns/1ps
`default_nettype none
module test_external_bus_interface;
  logic              clk, srst, link_clk, bus_mode_select, cfg_load;
  logic              req_valid, req_ready, rsp_valid, bus_mode, busy;
  logic              ext_wait, hold_request, hold_acknowledge, slow;
  logic              system_clock_out, link_probe, link_probe_sync;
  logic [3:0]        cfg_area_width16, area_width16;
  logic [11:0]       cfg_area_waits, area_waits;
  logic [7:0]        upper_address, upper_pin_func_select;
  logic [7:0]        upper_port_latch, upper_port_pin;
  logic [15:0]       rsp_rdata, lower_address, lower_pin_func_select;
  logic [15:0]       lower_port_latch, lower_port_dir_out;
  logic [15:0]       lower_port_pin_in, lower_port_pin, lower_port_pin_oe;
  ebi_pkg::ebi_req_t req;
  ebi_pkg::ebi_ctl_t ctl;
  int                num_errors = 0;
  int                n_compared = 0;
  int                cyc;
  int                n;
  int                wt [4] = '{0, 3, 5, 7};
  logic [15:0]       rd, dv;
  logic [23:0]       ad;
  ebi_top #(.UPPER_W(8)) i_dut (.clk, .srst, .link_clk, .bus_mode_select,
    .cfg_load, .cfg_area_width16, .cfg_area_waits, .req_valid, .req_ready,
    .req, .rsp_valid, .rsp_rdata, .bus_mode, .area_width16, .area_waits,
    .busy, .ext_wait, .hold_request, .hold_acknowledge, .system_clock_out,
    .ctl, .lower_address, .upper_address, .upper_pin_func_select,
    .upper_port_latch, .upper_port_pin, .lower_pin_func_select,
    .lower_port_latch, .lower_port_dir_out, .lower_port_pin_in,
    .lower_port_pin, .lower_port_pin_oe, .link_probe, .link_probe_sync);
  ebi_mem_model i_mem (.clk, .sep(bus_mode), .slow, .ctl, .lower_address,
    .pin_out(lower_port_pin), .pin_oe(lower_port_pin_oe),
    .pin_in(lower_port_pin_in), .ext_wait);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #15 link_clk = ~link_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("errors %0d compares %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // One bus request; returns read data and clocks from take to answer
  task automatic op(input logic w, input logic [23:0] a,
                    input logic [15:0] d, input logic in);
    int k;
    k = 0;
    req = '{write: w, byte_en: 2'h3, addr: a, wdata: d, internal: in};
    req_valid = 1'b1;
    do begin @(negedge clk); k++; end while (!req_ready && k < 200);
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    cyc = 0;
    do begin @(posedge clk); #1; cyc++; end while (!rsp_valid && cyc < 200);
    rd = rsp_rdata;
  endtask
  task automatic cfg(input logic [3:0] w, input logic [11:0] t);
    cfg_area_width16 = w;
    cfg_area_waits = t;
    cfg_load = 1'b1;
    @(posedge clk);
    #1;
    cfg_load = 1'b0;
  endtask
  initial begin
    #400000;
    num_errors++;
    give_verdict();
  end
  initial begin
    srst = 1'b1; bus_mode_select = 1'b0; cfg_load = 1'b0; slow = 1'b0;
    cfg_area_width16 = 4'hF; cfg_area_waits = 12'hFFF; req_valid = 1'b0;
    req = '0; hold_request = 1'b0; link_probe = 1'b0;
    upper_pin_func_select = 8'hFF; upper_port_latch = 8'hA5;
    lower_pin_func_select = 16'hFFFF; lower_port_latch = 16'h1234;
    lower_port_dir_out = 16'h00FF;
    repeat (6) @(posedge clk);
    #1;
    srst = 1'b0;
    check(area_waits, 12'hFFF);
    check(area_width16, 4'hF);
    check(link_probe_sync, 1'b0);
    check(bus_mode, 1'b0);
    check(ctl.area_select_n, 4'hF);
    op(1'b1, 24'h000020, 16'hC3A5, 1'b0);
    check(cyc, 10);
    cfg(4'hF, 12'hF58);
    for (int m = 0; m < 2; m++) begin
      bus_mode_select = m[0];
      repeat (2) @(posedge clk);
      #1;
      check(bus_mode, m[0]);
      for (int a = 0; a < 4; a++) begin
        ad = {1'b0, a[1:0], 21'(64 + 8 * m + 2 * a)};
        dv = 16'(16'h3C00 + 16 * m + a);
        op(1'b1, ad, dv, 1'b0);
        check(cyc, 3 - m + wt[a]);
        op(1'b0, ad, 16'h0000, 1'b0);
        check(rd, dv);
        // Read answer comes one clock after the strobes end
        check(cyc, 4 - m + wt[a]);
        op(1'b1, ad, ~dv, 1'b1);
        op(1'b0, ad, 16'h0000, 1'b1);
        op(1'b0, ad, 16'h0000, 1'b0);
        check(rd, 16'(~dv));
      end
    end
    slow = 1'b1;
    // Area 1 has waits, so the late wait sample still lands in time
    op(1'b0, 24'h20004A, 16'h0000, 1'b0);
    slow = 1'b0;
    check(cyc > 6, 1'b1);
    check(rd, 16'hC3EE);
    cfg(4'hE, 12'h000);
    op(1'b1, 24'h000080, 16'h1122, 1'b0);
    check(cyc, 4);
    hold_request = 1'b1;
    n = 0;
    while (!hold_acknowledge && n < 20) begin @(posedge clk); #1; n++; end
    check(hold_acknowledge, 1'b1);
    check(req_ready, 1'b0);
    hold_request = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    check(hold_acknowledge, 1'b0);
    upper_pin_func_select = 8'h0F;
    lower_pin_func_select = 16'hFF00;
    link_probe = 1'b1;
    @(posedge clk);
    #1;
    check(upper_port_pin[7:4], 4'hA);
    check(lower_port_pin[7:0], 8'h34);
    check(lower_port_pin_oe[7:0], 8'hFF);
    @(negedge clk);
    #1;
    check(system_clock_out, 1'b0);
    repeat (10) @(posedge clk);
    #1;
    check(link_probe_sync, 1'b1);
    give_verdict();
  end
endmodule
`default_nettype wire
